// [dv/hlt_pix_src.sv]
// upstream pixel stream model: sync pulses and bayer quads
// assumes callers enter its tasks just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module hlt_pix_src
    import hlt_pkg::*;
(
    input  wire logic           sys_clk_i,
    output logic [2:0]          kind_o,
    output logic [4*SMP_W-1:0]  smp_o
);
    // kind bits: vsync, line start, quad valid
    initial kind_o = 3'h0;
    initial smp_o = '0;
    task automatic beat(input logic [2:0] k, input logic [4*SMP_W-1:0] s);
        {kind_o, smp_o} <= {k, s};
        @(posedge sys_clk_i);
    endtask : beat
    // idle samples toggle so stale data never matches
    task automatic idle();
        {kind_o, smp_o} <= {3'h0, ~smp_o};
        @(posedge sys_clk_i);
    endtask : idle
endmodule : hlt_pix_src
`default_nettype wire

// [dv/tb_histogram_luma_table_control.sv]
// bench for hlt_top: registers, luma, table clear, table select
// assumes hlt_pix_src as the pixel source
`timescale 1ns/10ps
`default_nettype none
module tb_histogram_luma_table_control
    import hlt_pkg::*;
;
    logic                     clk = 1'b0;
    logic                     resetn = 1'b0;
    logic                     psel = 1'b0;
    logic                     pen = 1'b0;
    logic                     pwr = 1'b0;
    logic [ADDR_W-1:0]        paddr = '0;
    logic [31:0]              pwd = '0;
    logic [31:0]              prd;
    logic                     prdy, perr, lv, cwe;
    logic [2:0]               kind;
    logic [4*SMP_W-1:0]       smp;
    logic signed [LUMA_W-1:0] luma;
    logic [TBL_AW-1:0]        cad, lad;
    logic [1:0]               tlo, thi;
    logic [32:0]              qr[$];
    logic signed [LUMA_W-1:0] ql[$];
    logic [31:0]              lfsr = 32'hff66;
    logic [WGT_W-1:0]         w[4];
    int                       num_errors = 0, n_checks = 0, ncl = 0;
    always #10 clk = ~clk;
    hlt_pix_src u_src (.sys_clk_i(clk), .kind_o(kind), .smp_o(smp));
    hlt_top u_dut (
        .sys_clk_i(clk), .resetn_i(resetn), .paddr_i(paddr),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd),
        .pready_o(prdy), .prdata_o(prd), .pslverr_o(perr),
        .vertical_sync_i(kind[2]), .line_start_i(kind[1]),
        .quad_valid_i(kind[0]), .red_sample_i(smp[47:36]),
        .green_red_row_sample_i(smp[35:24]),
        .green_blue_row_sample_i(smp[23:12]), .blue_sample_i(smp[11:0]),
        .luma_o(luma), .luma_valid_o(lv), .tbl_clr_we_o(cwe),
        .tbl_clr_addr_o(cad), .out_tbl_lo_o(tlo), .out_tbl_hi_o(thi));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("errors=%0d checks=%0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    function automatic logic [31:0] nx(input logic [31:0] v);
        nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nx
    function automatic logic signed [LUMA_W-1:0] ly(
        input logic [4*SMP_W-1:0] s);
        ly = $signed({1'b0, s[47:36]}) * $signed(w[0])
           + $signed({1'b0, s[35:24]}) * $signed(w[1])
           + $signed({1'b0, s[23:12]}) * $signed(w[2])
           + $signed({1'b0, s[11:0]}) * $signed(w[3]);
    endfunction : ly
    // apb: setup, access held until pready
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        {psel, pwr, paddr, pwd} <= {1'b1, wr, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] e);
        qr.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic frame(input logic clr);
        logic [4*SMP_W-1:0] s;
        u_src.beat(3'h4, '0);
        for (int v = 0; v < 4; v++) begin
            if (v > 0) u_src.beat(3'h2, '0);
            for (int h = 0; h <= 8; h += 2) begin
                lfsr = nx(lfsr);
                s = {lfsr[23:0], lfsr[31:8]};
                if (h >= 2 && h <= 6 && v <= 2 && !(clr && v == 0))
                    ql.push_back(ly(s));
                u_src.beat(3'h1, s);
            end
        end
        u_src.idle();
    endtask : frame
    always @(negedge clk) begin
        if (prdy === 1'b1 && pwr === 1'b0)
            chk({perr, prd}, qr.pop_front());
        if (lv === 1'b1)
            chk(33'(luma), ql.size() ? 33'(ql.pop_front()) : '1);
        if (cwe === 1'b1) begin
            ncl++;
            lad = cad;
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(12'h100, 33'h100000000);
        for (int i = 0; i < 5; i++)
            rd(12'(4 * i), '0);
        for (int i = 0; i < 4; i++) begin
            lfsr = nx(lfsr);
            w[i] = lfsr[7:0];
            apb(1'b1, OFS_W_RED + 12'(4 * i), {24'h0, w[i]});
            rd(OFS_W_RED + 12'(4 * i), {25'h0, w[i]});
        end
        apb(1'b1, OFS_REG_HPS, 32'h2);
        apb(1'b1, OFS_REG_HSZ, 32'h4);
        apb(1'b1, OFS_REG_VSZ, 32'h2);
        frame(1'b0);
        repeat (300) @(posedge clk);
        chk(33'(ncl), 33'h0);
        apb(1'b1, OFS_TBL_CTRL, 32'h3);
        chk(33'({tlo, thi}), 33'h1);
        frame(1'b1);
        repeat (300) @(posedge clk);
        chk(33'(ncl), 33'd256);
        chk(33'(lad), 33'hff);
        chk(33'({tlo, thi}), 33'hb);
        rd(OFS_STATUS, 33'h1);
        chk(33'(ql.size() + qr.size()), 33'h0);
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule : tb_histogram_luma_table_control
`default_nettype wire

// [hdl/hlt_apb_regs.sv]
// apb register file for the histogram luma and table control block
// assumes a single clock and zero wait apb master behaviour is allowed
`timescale 1ns/10ps
`default_nettype none
module hlt_apb_regs
    import hlt_pkg::*;
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 resetn_i,
    input  wire logic [ADDR_W-1:0]    paddr_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [31:0]          pwdata_i,
    output logic                      pready_o,
    output logic [31:0]               prdata_o,
    output logic                      pslverr_o,
    input  wire logic                 sel_applied_i,
    input  wire logic                 clear_busy_i,
    output logic                      table_clear_enable_o,
    output logic                      table_sel_o,
    output logic [WGT_W-1:0]          red_weight_o,
    output logic [WGT_W-1:0]          green_red_row_weight_o,
    output logic [WGT_W-1:0]          green_blue_row_weight_o,
    output logic [WGT_W-1:0]          blue_weight_o,
    output logic [POS_W-1:0]          region_hstart_o,
    output logic [POS_W-1:0]          region_hsize_o,
    output logic [POS_W-1:0]          region_vstart_o,
    output logic [POS_W-1:0]          region_vsize_o
);

    typedef struct packed {
        logic             clr;
        logic             sel;
        logic [WGT_W-1:0] w_r;
        logic [WGT_W-1:0] w_gr;
        logic [WGT_W-1:0] w_gb;
        logic [WGT_W-1:0] w_b;
        logic [POS_W-1:0] hps;
        logic [POS_W-1:0] hsz;
        logic [POS_W-1:0] vps;
        logic [POS_W-1:0] vsz;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } hlt_reg_state_type;

    hlt_reg_state_type st_r;
    hlt_reg_state_type st_nxt;
    logic              wr_en;

    // read value and map hit, reserved bits zero
    function automatic logic [32:0] reg_read(
        input hlt_reg_state_type s,
        input logic [ADDR_W-1:0] a,
        input logic              sel_ap,
        input logic              busy
    );
        unique case (a)
            OFS_TBL_CTRL: reg_read = {1'b1, 30'h0, s.clr, s.sel};
            OFS_W_RED:    reg_read = {1'b1, 24'h0, s.w_r};
            OFS_W_GR_ROW: reg_read = {1'b1, 24'h0, s.w_gr};
            OFS_W_GB_ROW: reg_read = {1'b1, 24'h0, s.w_gb};
            OFS_W_BLUE:   reg_read = {1'b1, 24'h0, s.w_b};
            OFS_REG_HPS:  reg_read = {1'b1, 19'h0, s.hps};
            OFS_REG_HSZ:  reg_read = {1'b1, 19'h0, s.hsz};
            OFS_REG_VPS:  reg_read = {1'b1, 19'h0, s.vps};
            OFS_REG_VSZ:  reg_read = {1'b1, 19'h0, s.vsz};
            OFS_STATUS:   reg_read = {1'b1, 30'h0, busy, sel_ap};
            default:      reg_read = 33'h0_0000_0000;
        endcase
    endfunction : reg_read

    always_comb begin
        logic [32:0] rd;
        rd             = reg_read(st_r, paddr_i, sel_applied_i, clear_busy_i);
        st_nxt         = st_r;
        wr_en          = psel_i && penable_i && st_r.pready && pwrite_i
                         && !st_r.pslverr;
        st_nxt.pready  = psel_i && !penable_i;
        st_nxt.pslverr = psel_i && !penable_i && !rd[32];
        st_nxt.prdata  = (psel_i && !penable_i && !pwrite_i)
                         ? rd[31:0] : 32'h0000_0000;
        if (wr_en) begin
            unique case (paddr_i)
                OFS_TBL_CTRL: begin
                    st_nxt.clr = pwdata_i[BIT_TBL_CLR];
                    st_nxt.sel = pwdata_i[BIT_TBL_SEL];
                end
                OFS_W_RED:    st_nxt.w_r  = pwdata_i[WGT_W-1:0];
                OFS_W_GR_ROW: st_nxt.w_gr = pwdata_i[WGT_W-1:0];
                OFS_W_GB_ROW: st_nxt.w_gb = pwdata_i[WGT_W-1:0];
                OFS_W_BLUE:   st_nxt.w_b  = pwdata_i[WGT_W-1:0];
                // lowest bit of start and size is not writable
                OFS_REG_HPS:  st_nxt.hps = {pwdata_i[POS_W-1:1], 1'b0};
                OFS_REG_HSZ:  st_nxt.hsz = {pwdata_i[POS_W-1:1], 1'b0};
                OFS_REG_VPS:  st_nxt.vps = {pwdata_i[POS_W-1:1], 1'b0};
                OFS_REG_VSZ:  st_nxt.vsz = {pwdata_i[POS_W-1:1], 1'b0};
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            st_r     <= '0; // [RULE_09]
            st_r.w_r <= RST_WEIGHT;
            st_r.hps <= RST_START;
            st_r.hsz <= RST_SIZE;
            st_r.vps <= RST_START;
            st_r.vsz <= RST_SIZE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pready_o                = st_r.pready;
    assign prdata_o                = st_r.prdata;
    assign pslverr_o               = st_r.pslverr;
    assign table_clear_enable_o    = st_r.clr;
    assign table_sel_o             = st_r.sel;
    assign red_weight_o            = st_r.w_r;
    assign green_red_row_weight_o  = st_r.w_gr;
    assign green_blue_row_weight_o = st_r.w_gb;
    assign blue_weight_o           = st_r.w_b;
    assign region_hstart_o         = st_r.hps;
    assign region_hsize_o          = st_r.hsz;
    assign region_vstart_o         = st_r.vps;
    assign region_vsize_o          = st_r.vsz;

    AST_RST_ZERO: assert property (@(posedge sys_clk_i) // [RULE_09]
        !resetn_i |=> !table_clear_enable_o && !table_sel_o
            && red_weight_o == '0 && green_red_row_weight_o == '0
            && green_blue_row_weight_o == '0 && blue_weight_o == '0)
        else $error("control fields not zero after reset");

endmodule : hlt_apb_regs
`default_nettype wire

// [hdl/hlt_luma_calc.sv]
// luma sample from one bayer quad, one register stage
// assumes weights are stable static configuration
`timescale 1ns/10ps
`default_nettype none
module hlt_luma_calc
    import hlt_pkg::*;
(
    input  wire logic                     sys_clk_i,
    input  wire logic                     resetn_i,
    input  wire logic                     valid_i,
    input  wire logic [SMP_W-1:0]         red_sample_i,
    input  wire logic [SMP_W-1:0]         green_red_row_sample_i,
    input  wire logic [SMP_W-1:0]         green_blue_row_sample_i,
    input  wire logic [SMP_W-1:0]         blue_sample_i,
    input  wire logic [WGT_W-1:0]         red_weight_i,
    input  wire logic [WGT_W-1:0]         green_red_row_weight_i,
    input  wire logic [WGT_W-1:0]         green_blue_row_weight_i,
    input  wire logic [WGT_W-1:0]         blue_weight_i,
    output logic signed [LUMA_W-1:0]      luma_o,
    output logic                          luma_valid_o
);

    typedef struct packed {
        logic signed [LUMA_W-1:0] luma;
        logic                     valid;
    } hlt_calc_state_type;

    hlt_calc_state_type st_r;
    hlt_calc_state_type st_nxt;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.valid = valid_i;
        if (valid_i) begin
            // sum of four weighted colour terms [RULE_05]
            st_nxt.luma =
                LUMA_W'(hlt_term(red_sample_i, red_weight_i))        // [RULE_04]
              + LUMA_W'(hlt_term(green_red_row_sample_i,
                                 green_red_row_weight_i))          // [RULE_06]
              + LUMA_W'(hlt_term(green_blue_row_sample_i,
                                 green_blue_row_weight_i))         // [RULE_06]
              + LUMA_W'(hlt_term(blue_sample_i, blue_weight_i));   // [RULE_07]
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign luma_o       = st_r.luma;
    assign luma_valid_o = st_r.valid;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    AST_LUMA_SUM: assert property ( // [RULE_05]
        valid_i |=> luma_valid_o && luma_o ==
            LUMA_W'($past(hlt_term(red_sample_i, red_weight_i)))
          + LUMA_W'($past(hlt_term(green_red_row_sample_i,
                                   green_red_row_weight_i)))
          + LUMA_W'($past(hlt_term(green_blue_row_sample_i,
                                   green_blue_row_weight_i)))
          + LUMA_W'($past(hlt_term(blue_sample_i, blue_weight_i))))
        else $error("luma is not the weighted quad sum");

    AST_RED_ONLY: assert property ( // [RULE_04]
        valid_i && green_red_row_weight_i == '0
            && green_blue_row_weight_i == '0 && blue_weight_i == '0
        |=> luma_o == LUMA_W'(signed'({1'b0, $past(red_sample_i)}))
                   * LUMA_W'(signed'($past(red_weight_i))))
        else $error("red weight not applied as signed s4.4");

    AST_GREEN_SITE: assert property ( // [RULE_06]
        valid_i && red_weight_i == '0 && blue_weight_i == '0
            && green_blue_row_weight_i == '0
        |=> luma_o == LUMA_W'($past(hlt_term(green_red_row_sample_i,
                                             green_red_row_weight_i))))
        else $error("green red row weight on wrong site");

endmodule : hlt_luma_calc
`default_nettype wire

// [hdl/hlt_top.sv]
// histogram luma and table control top: apb registers, frame
// tracking, table clear sweep, output table pair and region gating
// assumes pixel stream inputs are synchronous to sys_clk_i
//
// Notes on behaviour
// RULE_01: table clear bit erases table at vsync
// RULE_02: no sampling on first line while clearing
// RULE_03: select bit picks tables 0-1 or 2-3
// RULE_04: red weight is signed s4.4, bits 7-0
// RULE_05: luma is sum of four weighted samples
// RULE_06: separate weights for each green site
// RULE_07: blue weight is signed s4.4, bits 7-0
// RULE_08: software writes zero to reserved bits
// RULE_09: control and weights reset to zero
// RULE_10: region covers size plus one from start
// RULE_11: table selection changes at frame boundary
`timescale 1ns/10ps
`default_nettype none
module hlt_top
    import hlt_pkg::*;
(
    input  wire logic                     sys_clk_i,
    input  wire logic                     resetn_i,
    input  wire logic [ADDR_W-1:0]        paddr_i,
    input  wire logic                     psel_i,
    input  wire logic                     penable_i,
    input  wire logic                     pwrite_i,
    input  wire logic [31:0]              pwdata_i,
    output logic                          pready_o,
    output logic [31:0]                   prdata_o,
    output logic                          pslverr_o,
    input  wire logic                     vertical_sync_i,
    input  wire logic                     line_start_i,
    input  wire logic                     quad_valid_i,
    input  wire logic [SMP_W-1:0]         red_sample_i,
    input  wire logic [SMP_W-1:0]         green_red_row_sample_i,
    input  wire logic [SMP_W-1:0]         green_blue_row_sample_i,
    input  wire logic [SMP_W-1:0]         blue_sample_i,
    output logic signed [LUMA_W-1:0]      luma_o,
    output logic                          luma_valid_o,
    output logic                          tbl_clr_we_o,
    output logic [TBL_AW-1:0]             tbl_clr_addr_o,
    output logic [1:0]                    out_tbl_lo_o,
    output logic [1:0]                    out_tbl_hi_o
);

    typedef struct packed {
        hlt_clr_state_type cst;
        logic [TBL_AW-1:0] clr_addr;
        logic              clr_we;
        logic [POS_W:0]    hpos;
        logic [POS_W:0]    vpos;
        logic              clr_frame;
        logic              sel_applied;
        logic [1:0]        tbl_lo;
        logic [1:0]        tbl_hi;
    } hlt_top_state_type;

    hlt_top_state_type st_r;
    hlt_top_state_type st_nxt;

    logic              tbl_clr;
    logic              tbl_sel;
    logic [WGT_W-1:0]  w_r;
    logic [WGT_W-1:0]  w_gr;
    logic [WGT_W-1:0]  w_gb;
    logic [WGT_W-1:0]  w_b;
    logic [POS_W-1:0]  hps;
    logic [POS_W-1:0]  hsz;
    logic [POS_W-1:0]  vps;
    logic [POS_W-1:0]  vsz;
    logic              first_blk;
    logic              in_region;
    logic              gate;

    hlt_apb_regs u_regs (
        .sys_clk_i               (sys_clk_i),
        .resetn_i                (resetn_i),
        .paddr_i                 (paddr_i),
        .psel_i                  (psel_i),
        .penable_i               (penable_i),
        .pwrite_i                (pwrite_i),
        .pwdata_i                (pwdata_i),
        .pready_o                (pready_o),
        .prdata_o                (prdata_o),
        .pslverr_o               (pslverr_o),
        .sel_applied_i           (st_r.sel_applied),
        .clear_busy_i            (st_r.clr_we),
        .table_clear_enable_o    (tbl_clr),
        .table_sel_o             (tbl_sel),
        .red_weight_o            (w_r),
        .green_red_row_weight_o  (w_gr),
        .green_blue_row_weight_o (w_gb),
        .blue_weight_o           (w_b),
        .region_hstart_o         (hps),
        .region_hsize_o          (hsz),
        .region_vstart_o         (vps),
        .region_vsize_o          (vsz)
    );

    // sample gating for the current quad
    always_comb begin
        first_blk = st_r.clr_frame && (st_r.vpos == '0); // [RULE_02]
        in_region = hlt_in_span(st_r.hpos, hps, hsz)
                    && hlt_in_span(st_r.vpos, vps, vsz); // [RULE_10]
        gate      = quad_valid_i && !vertical_sync_i && !line_start_i
                    && in_region && !first_blk;
    end

    hlt_luma_calc u_calc (
        .sys_clk_i               (sys_clk_i),
        .resetn_i                (resetn_i),
        .valid_i                 (gate),
        .red_sample_i            (red_sample_i),
        .green_red_row_sample_i  (green_red_row_sample_i),
        .green_blue_row_sample_i (green_blue_row_sample_i),
        .blue_sample_i           (blue_sample_i),
        .red_weight_i            (w_r),
        .green_red_row_weight_i  (w_gr),
        .green_blue_row_weight_i (w_gb),
        .blue_weight_i           (w_b),
        .luma_o                  (luma_o),
        .luma_valid_o            (luma_valid_o)
    );

    always_comb begin
        st_nxt = st_r;
        // clear sweep over the whole table memory
        unique case (st_r.cst)
            CLR_IDLE: begin
            end
            CLR_SWEEP: begin
                if (st_r.clr_addr == TBL_LAST) begin
                    st_nxt.cst = CLR_IDLE;
                end else begin
                    st_nxt.clr_addr = st_r.clr_addr + 1'b1;
                end
            end
        endcase
        if (vertical_sync_i) begin
            st_nxt.hpos        = '0;
            st_nxt.vpos        = '0;
            st_nxt.clr_frame   = tbl_clr;                     // [RULE_02]
            st_nxt.sel_applied = tbl_sel;                     // [RULE_11]
            st_nxt.tbl_lo      = tbl_sel ? TBL_PAIR1 : TBL_PAIR0; // [RULE_03]
            st_nxt.tbl_hi      = (tbl_sel ? TBL_PAIR1 : TBL_PAIR0) + 2'h1;
            if (tbl_clr) begin
                st_nxt.cst      = CLR_SWEEP;                  // [RULE_01]
                st_nxt.clr_addr = '0;
            end
        end else if (line_start_i) begin
            st_nxt.hpos = '0;
            st_nxt.vpos = st_r.vpos + 1'b1;
        end else if (quad_valid_i) begin
            st_nxt.hpos = st_r.hpos + QUAD_STEP;
        end
        st_nxt.clr_we = (st_nxt.cst == CLR_SWEEP);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            st_r        <= '0;
            st_r.cst    <= CLR_IDLE;
            st_r.tbl_lo <= TBL_PAIR0;
            st_r.tbl_hi <= 2'h1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tbl_clr_we_o   = st_r.clr_we;
    assign tbl_clr_addr_o = st_r.clr_addr;
    assign out_tbl_lo_o   = st_r.tbl_lo;
    assign out_tbl_hi_o   = st_r.tbl_hi;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_clr_vsync;
        vertical_sync_i && tbl_clr;
    endsequence

    sequence s_sweep_start;
        tbl_clr_we_o && tbl_clr_addr_o == '0;
    endsequence

    sequence s_sweep_end;
        tbl_clr_we_o && tbl_clr_addr_o == TBL_LAST && !vertical_sync_i;
    endsequence

    AST_CLR_START: assert property ( // [RULE_01]
        s_clr_vsync |=> s_sweep_start ##1 tbl_clr_we_o
            && tbl_clr_addr_o == 8'h01)
        else $error("table clear sweep did not start at vsync");

    AST_CLR_END: assert property ( // [RULE_01]
        s_sweep_end |=> !tbl_clr_we_o)
        else $error("table clear sweep ran past the last entry");

    AST_NO_CLR: assert property ( // [RULE_01]
        vertical_sync_i && !tbl_clr && !tbl_clr_we_o |=> !tbl_clr_we_o)
        else $error("table cleared while clear is disabled");

    AST_FIRST_LINE: assert property ( // [RULE_02]
        s_clr_vsync ##1 (!line_start_i && !vertical_sync_i) [*2]
        |=> !luma_valid_o)
        else $error("first line sampled while clearing");

    AST_SEL_PAIR: assert property ( // [RULE_03]
        vertical_sync_i |=> out_tbl_lo_o == ($past(tbl_sel) ? 2'h2 : 2'h0)
            && out_tbl_hi_o == ($past(tbl_sel) ? 2'h3 : 2'h1))
        else $error("output table pair does not follow select");

    AST_SEL_FRAME: assert property ( // [RULE_11]
        !vertical_sync_i |=> $stable(out_tbl_lo_o) && $stable(out_tbl_hi_o))
        else $error("table pair changed inside a frame");

    AST_REGION_IN: assert property ( // [RULE_10]
        quad_valid_i && !vertical_sync_i && !line_start_i
            && st_r.hpos == {1'b0, hps} && st_r.vpos == {1'b0, vps}
            && !first_blk
        |=> luma_valid_o)
        else $error("region start pixel not sampled");

    AST_REGION_OUT: assert property ( // [RULE_10]
        quad_valid_i && st_r.hpos == ({1'b0, hps} + {1'b0, hsz} + QUAD_STEP)
        |=> !luma_valid_o)
        else $error("pixel past region size plus one sampled");

endmodule : hlt_top
`default_nettype wire

// [inc/hlt_pkg.sv]
// package for the histogram luma and table control block
// assumes a 32-bit apb register bus and 12-bit bayer samples
package hlt_pkg;

    // apb register byte offsets
    localparam logic [11:0] OFS_TBL_CTRL  = 12'h000;
    localparam logic [11:0] OFS_W_RED     = 12'h004;
    localparam logic [11:0] OFS_W_GR_ROW  = 12'h008;
    localparam logic [11:0] OFS_W_GB_ROW  = 12'h00c;
    localparam logic [11:0] OFS_W_BLUE    = 12'h010;
    localparam logic [11:0] OFS_REG_HPS   = 12'h014;
    localparam logic [11:0] OFS_REG_HSZ   = 12'h018;
    localparam logic [11:0] OFS_REG_VPS   = 12'h01c;
    localparam logic [11:0] OFS_REG_VSZ   = 12'h020;
    localparam logic [11:0] OFS_STATUS    = 12'h024;

    // field positions
    localparam int          BIT_TBL_SEL   = 0;
    localparam int          BIT_TBL_CLR   = 1;
    localparam int          BIT_ST_SEL    = 0;
    localparam int          BIT_ST_BUSY   = 1;

    // widths
    localparam int          ADDR_W        = 12;
    localparam int          SMP_W         = 12;
    localparam int          WGT_W         = 8;
    localparam int          POS_W         = 13;
    localparam int          PROD_W        = SMP_W + 1 + WGT_W;
    localparam int          LUMA_W        = PROD_W + 2;
    localparam int          TBL_AW        = 8;

    // reset values
    localparam logic [WGT_W-1:0] RST_WEIGHT = 8'h00;
    localparam logic [POS_W-1:0] RST_START  = 13'h0000;
    localparam logic [POS_W-1:0] RST_SIZE   = 13'h0001;

    // table memory sweep, output table pairs and quad position step
    localparam logic [TBL_AW-1:0] TBL_LAST  = 8'hff;
    localparam logic [1:0]        TBL_PAIR0 = 2'h0;
    localparam logic [1:0]        TBL_PAIR1 = 2'h2;
    localparam logic [POS_W:0]    QUAD_STEP = 14'h0002;

    typedef enum logic {
        CLR_IDLE,
        CLR_SWEEP
    } hlt_clr_state_type;

    // unsigned sample times s4.4 weight
    function automatic logic signed [PROD_W-1:0] hlt_term(
        input logic [SMP_W-1:0] smp,
        input logic [WGT_W-1:0] wgt
    );
        logic signed [PROD_W-1:0] a;
        logic signed [PROD_W-1:0] b;
        a = signed'({{(WGT_W+1){1'b0}}, smp});
        b = signed'({{(SMP_W+1){wgt[WGT_W-1]}}, wgt});
        hlt_term = PROD_W'(a * b);
    endfunction : hlt_term

    // region span check, inclusive of start plus size
    function automatic logic hlt_in_span(
        input logic [POS_W:0]   pos,
        input logic [POS_W-1:0] start,
        input logic [POS_W-1:0] size
    );
        logic [POS_W:0] last;
        last = {1'b0, start} + {1'b0, size};
        hlt_in_span = (pos >= {1'b0, start}) && (pos <= last);
    endfunction : hlt_in_span

endpackage : hlt_pkg
